// ===== logic/armp_read_port.sv
// Bus read master port: address channel, data channel, spec-read returns
//
// Contract
// - Drive a 9-bit user attribute sideband with every read request.
// - With bus check option on, accept 8 check bits per data beat.
// - Read identifier width is a build-time parameter.
// - With coherency slave port built, id width is its id bits plus one.
// - Without coherency slave port, read ids are five bits wide.
// - Accept a 4-bit speculative read completion status from the cache.
// - Accept a speculative read id as wide as the read id.
// - Sample port inputs only on clock edges with input enable high; the request inputs load on output enable and beat_ready is not gated.
// - Change port outputs only on clock edges with output enable high; the beat and spec outputs, and the first rise of req_ready after reset, change without it.
`timescale 1ns/1ps
module armp_read_port #(
  parameter bit COH_PORT_EN   = 1'b0,
  parameter int COH_ID_BITS   = 4,
  parameter bit BUS_ECC_EN    = 1'b0,
  parameter int ID_W          = COH_PORT_EN ? COH_ID_BITS + 1
                                            : armp_pkg::NO_COH_ID_W,
  parameter int DEPTH         = armp_pkg::FIFO_DEPTH
)(
  input  wire logic                          mclk,
  input  wire logic                          reset_n,
  input  wire logic                          in_clock_enable,
  input  wire logic                          out_clock_enable,
  input  wire logic                          req_valid,
  output logic                               req_ready,
  input  wire logic [ID_W-1:0]               req_id,
  input  wire logic [armp_pkg::LOCK_W-1:0]   req_lock,
  input  wire logic [armp_pkg::PROT_W-1:0]   req_prot,
  input  wire logic [armp_pkg::SIZE_W-1:0]   req_size,
  input  wire logic [armp_pkg::USER_W-1:0]   req_user,
  output logic [ID_W-1:0]                    rd_request_id,
  output logic [armp_pkg::LOCK_W-1:0]        rd_lock_type,
  output logic [armp_pkg::PROT_W-1:0]        rd_prot,
  output logic [armp_pkg::SIZE_W-1:0]        rd_beat_size,
  output logic [armp_pkg::USER_W-1:0]        rd_addr_user_attr,
  output logic                               rd_addr_valid,
  input  wire logic                          rd_addr_ready,
  input  wire logic [armp_pkg::DATA_W-1:0]   rd_data,
  input  wire logic [armp_pkg::CHECK_W-1:0]  rd_data_check_bits,
  input  wire logic [ID_W-1:0]               rd_data_id,
  input  wire logic                          rd_last,
  input  wire logic [armp_pkg::RESP_W-1:0]   rd_resp,
  input  wire logic                          rd_valid,
  output logic                               rd_ready,
  input  wire logic [armp_pkg::SPEC_W-1:0]   spec_read_info,
  input  wire logic [ID_W-1:0]               spec_read_id,
  output logic                               beat_valid,
  input  wire logic                          beat_ready,
  output logic [armp_pkg::DATA_W-1:0]        beat_data,
  output logic [armp_pkg::CHECK_W-1:0]       beat_check,
  output logic [ID_W-1:0]                    beat_id,
  output logic                               beat_last,
  output logic [armp_pkg::RESP_W-1:0]        beat_resp,
  output logic                               spec_valid,
  output logic [armp_pkg::SPEC_W-1:0]        spec_info,
  output logic [ID_W-1:0]                    spec_id
);
  localparam int BEAT_W = armp_pkg::CHECK_W + armp_pkg::DATA_W + ID_W
                          + 1 + armp_pkg::RESP_W;
  localparam int CW     = $clog2(DEPTH) + 1;

  ////////////////////////////////////////////////////////////////////////
  // Read address channel
  armp_pkg::armp_ar_state_type ar_state_reg;
  armp_pkg::armp_ar_state_type ar_state_next;
  logic [ID_W-1:0]             ar_id_reg;
  logic [ID_W-1:0]             ar_id_next;
  logic [armp_pkg::LOCK_W-1:0] ar_lock_reg;
  logic [armp_pkg::LOCK_W-1:0] ar_lock_next;
  logic [armp_pkg::PROT_W-1:0] ar_prot_reg;
  logic [armp_pkg::PROT_W-1:0] ar_prot_next;
  logic [armp_pkg::SIZE_W-1:0] ar_size_reg;
  logic [armp_pkg::SIZE_W-1:0] ar_size_next;
  logic [armp_pkg::USER_W-1:0] ar_user_reg;
  logic [armp_pkg::USER_W-1:0] ar_user_next;
  logic                        ar_valid_reg;
  logic                        ar_valid_next;
  logic                        req_ready_reg;
  logic                        req_ready_next;
  logic                        ar_load;
  logic                        ar_hs;

  assign ar_hs = in_clock_enable && rd_addr_ready;

  always_comb
  begin
    ar_state_next = ar_state_reg;
    ar_valid_next = ar_valid_reg;
    ar_load       = 1'b0;
    unique case (ar_state_reg)
      armp_pkg::ARMP_AR_IDLE:
        if (out_clock_enable && req_valid && req_ready_reg)
        begin
          ar_load       = 1'b1;
          ar_valid_next = 1'b1;
          ar_state_next = armp_pkg::ARMP_AR_VALID;
        end
      armp_pkg::ARMP_AR_VALID:
        if (ar_hs && out_clock_enable)
        begin
          ar_valid_next = 1'b0;
          ar_state_next = armp_pkg::ARMP_AR_IDLE;
        end
        // Accepted but valid may not fall until the output enable
        else if (ar_hs)
          ar_state_next = armp_pkg::ARMP_AR_DONE;
      armp_pkg::ARMP_AR_DONE:
        if (out_clock_enable)
        begin
          ar_valid_next = 1'b0;
          ar_state_next = armp_pkg::ARMP_AR_IDLE;
        end
      default:
      begin
        ar_valid_next = 1'b0;
        ar_state_next = armp_pkg::ARMP_AR_IDLE;
      end
    endcase
    req_ready_next = ar_state_next == armp_pkg::ARMP_AR_IDLE;
    ar_id_next     = ar_load ? req_id   : ar_id_reg;
    ar_lock_next   = ar_load ? req_lock : ar_lock_reg;
    ar_prot_next   = ar_load ? req_prot : ar_prot_reg;
    ar_size_next   = ar_load ? req_size : ar_size_reg;
    ar_user_next   = ar_load ? req_user : ar_user_reg;
  end

  always_ff @(posedge mclk or negedge reset_n)
  begin
    if (!reset_n)
    begin
      ar_state_reg  <= armp_pkg::ARMP_AR_IDLE;
      ar_valid_reg  <= armp_pkg::RST_LOW;
      req_ready_reg <= armp_pkg::RST_LOW;
      ar_id_reg     <= '0;
      ar_lock_reg   <= armp_pkg::LOCK_NORMAL;
      ar_prot_reg   <= '0;
      ar_size_reg   <= armp_pkg::SIZE_8;
      ar_user_reg   <= '0;
    end
    else
    begin
      ar_state_reg  <= ar_state_next;
      ar_valid_reg  <= ar_valid_next;
      req_ready_reg <= req_ready_next;
      ar_id_reg     <= ar_id_next;
      ar_lock_reg   <= ar_lock_next;
      ar_prot_reg   <= ar_prot_next;
      ar_size_reg   <= ar_size_next;
      ar_user_reg   <= ar_user_next;
    end
  end

  assign req_ready         = req_ready_reg;
  assign rd_addr_valid     = ar_valid_reg;
  assign rd_request_id     = ar_id_reg;
  assign rd_lock_type      = ar_lock_reg;
  assign rd_prot           = ar_prot_reg;
  assign rd_beat_size      = ar_size_reg;
  assign rd_addr_user_attr = ar_user_reg;

  ////////////////////////////////////////////////////////////////////////
  // Read data channel into the beat buffer
  armp_stream_if #(.W(BEAT_W)) fill_s ();
  armp_stream_if #(.W(BEAT_W)) drain_s ();
  logic [CW-1:0]                fifo_count;
  logic                         r_ready_reg;
  logic                         r_ready_next;
  logic [armp_pkg::CHECK_W-1:0] check_in;

  // Check bits read as zero when the option is not built
  assign check_in = BUS_ECC_EN ? rd_data_check_bits : '0;

  assign fill_s.valid = in_clock_enable && rd_valid && r_ready_reg;
  assign fill_s.data  = {check_in, rd_data, rd_data_id, rd_last, rd_resp};

  // Headroom covers the beat that can land before ready can fall
  always_comb
  begin
    r_ready_next = r_ready_reg;
    if (out_clock_enable)
      r_ready_next = (CW'(DEPTH) - fifo_count) >= CW'(armp_pkg::RREADY_HEADROOM);
  end

  always_ff @(posedge mclk or negedge reset_n)
  begin
    if (!reset_n)
      r_ready_reg <= armp_pkg::RST_LOW;
    else
      r_ready_reg <= r_ready_next;
  end

  assign rd_ready = r_ready_reg;

  armp_fifo #(
    .W     (BEAT_W),
    .DEPTH (DEPTH)
  ) u_beat_fifo (
    .mclk    (mclk),
    .reset_n (reset_n),
    .fill    (fill_s.snk),
    .drain   (drain_s.src),
    .count   (fifo_count)
  );

  assign drain_s.ready = beat_ready;
  assign beat_valid    = drain_s.valid;
  assign {beat_check, beat_data, beat_id, beat_last, beat_resp} = drain_s.data;

  ////////////////////////////////////////////////////////////////////////
  // Speculative read returns from the cache controller
  logic                        sp_valid_reg;
  logic                        sp_valid_next;
  logic [armp_pkg::SPEC_W-1:0] sp_info_reg;
  logic [armp_pkg::SPEC_W-1:0] sp_info_next;
  logic [ID_W-1:0]             sp_id_reg;
  logic [ID_W-1:0]             sp_id_next;

  always_comb
  begin
    sp_valid_next = in_clock_enable && (spec_read_info != armp_pkg::SPEC_NONE);
    sp_info_next  = sp_info_reg;
    sp_id_next    = sp_id_reg;
    if (sp_valid_next)
    begin
      sp_info_next = spec_read_info;
      sp_id_next   = spec_read_id;
    end
  end

  always_ff @(posedge mclk or negedge reset_n)
  begin
    if (!reset_n)
    begin
      sp_valid_reg <= armp_pkg::RST_LOW;
      sp_info_reg  <= armp_pkg::SPEC_NONE;
      sp_id_reg    <= '0;
    end
    else
    begin
      sp_valid_reg <= sp_valid_next;
      sp_info_reg  <= sp_info_next;
      sp_id_reg    <= sp_id_next;
    end
  end

  assign spec_valid = sp_valid_reg;
  assign spec_info  = sp_info_reg;
  assign spec_id    = sp_id_reg;
endmodule

// ===== logic/armp_pkg.sv
// Constants and types for the read master port
package armp_pkg;
  localparam int DATA_W      = 64;
  localparam int CHECK_W     = 8;
  localparam int USER_W      = 9;
  localparam int PROT_W      = 3;
  localparam int LOCK_W      = 2;
  localparam int SIZE_W      = 2;
  localparam int RESP_W      = 2;
  localparam int SPEC_W      = 4;
  localparam int NO_COH_ID_W = 5;
  localparam int FIFO_DEPTH  = 4;
  localparam int RREADY_HEADROOM = 2;

  localparam logic [LOCK_W-1:0] LOCK_NORMAL    = 2'h0;
  localparam logic [LOCK_W-1:0] LOCK_EXCLUSIVE = 2'h1;
  localparam logic [LOCK_W-1:0] LOCK_LOCKED    = 2'h2;
  localparam logic [SIZE_W-1:0] SIZE_8         = 2'h0;
  localparam logic [SIZE_W-1:0] SIZE_16        = 2'h1;
  localparam logic [SIZE_W-1:0] SIZE_32        = 2'h2;
  localparam logic [SIZE_W-1:0] SIZE_64        = 2'h3;

  localparam logic [SPEC_W-1:0] SPEC_NONE = 4'h0;
  localparam logic              RST_LOW   = 1'h0;

  typedef enum logic [1:0] {
    ARMP_AR_IDLE  = 2'h0,
    ARMP_AR_VALID = 2'h1,
    ARMP_AR_DONE  = 2'h3
  } armp_ar_state_type;
endpackage

// ===== logic/armp_stream_if.sv
// Valid/ready word stream between the port and its buffer
`timescale 1ns/1ps
interface armp_stream_if #(
  parameter int W = 8
);
  logic         valid;
  logic         ready;
  logic [W-1:0] data;
  modport src (output valid, output data, input ready);
  modport snk (input valid, input data, output ready);
endinterface

// ===== logic/armp_fifo.sv
// Flip-flop FIFO with valid/ready on both sides
`timescale 1ns/1ps
module armp_fifo #(
  parameter int W     = 8,
  parameter int DEPTH = 4
)(
  input  wire logic   mclk,
  input  wire logic   reset_n,
  armp_stream_if.snk  fill,
  armp_stream_if.src  drain,
  output logic [$clog2(DEPTH):0] count
);
  localparam int AW = $clog2(DEPTH);
  localparam int CW = AW + 1;

  logic [W-1:0]  mem_reg [DEPTH];
  logic [AW-1:0] wr_ptr_reg;
  logic [AW-1:0] wr_ptr_next;
  logic [AW-1:0] rd_ptr_reg;
  logic [AW-1:0] rd_ptr_next;
  logic [CW-1:0] count_reg;
  logic [CW-1:0] count_next;
  logic          push;
  logic          pop;

  assign fill.ready  = count_reg != CW'(DEPTH);
  assign drain.valid = count_reg != '0;
  assign drain.data  = mem_reg[rd_ptr_reg];
  assign count       = count_reg;
  assign push        = fill.valid && fill.ready;
  assign pop         = drain.valid && drain.ready;

  always_comb
  begin
    wr_ptr_next = wr_ptr_reg;
    rd_ptr_next = rd_ptr_reg;
    count_next  = count_reg;
    if (push)
      wr_ptr_next = (wr_ptr_reg == AW'(DEPTH - 1)) ? '0 : wr_ptr_reg + 1'b1;
    if (pop)
      rd_ptr_next = (rd_ptr_reg == AW'(DEPTH - 1)) ? '0 : rd_ptr_reg + 1'b1;
    if (push && !pop)
      count_next = count_reg + 1'b1;
    else if (pop && !push)
      count_next = count_reg - 1'b1;
  end

  always_ff @(posedge mclk or negedge reset_n)
  begin
    if (!reset_n)
    begin
      wr_ptr_reg <= '0;
      rd_ptr_reg <= '0;
      count_reg  <= '0;
    end
    else
    begin
      wr_ptr_reg <= wr_ptr_next;
      rd_ptr_reg <= rd_ptr_next;
      count_reg  <= count_next;
    end
  end

  // Storage needs no reset; valid guards every read
  genvar i;
  generate
    for (i = 0; i < DEPTH; i++)
    begin : g_word
      always_ff @(posedge mclk)
      begin
        if (push && wr_ptr_reg == AW'(i))
          mem_reg[i] <= fill.data;
      end
    end
  endgenerate
endmodule

// ===== tb/armp_read_port_sva.sv
// Pin-level checks for the read master port
`timescale 1ns/1ps
module armp_read_port_chk #(
  parameter bit BUS_ECC_EN = 1'b0,
  parameter int ID_W       = 5
)(
  input wire logic            mclk,
  input wire logic            reset_n,
  input wire logic            in_clock_enable,
  input wire logic            out_clock_enable,
  input wire logic            req_valid,
  input wire logic            req_ready,
  input wire logic            rd_addr_valid,
  input wire logic            rd_addr_ready,
  input wire logic            rd_valid,
  input wire logic            rd_ready,
  input wire logic            beat_valid,
  input wire logic            beat_ready,
  input wire logic            spec_valid,
  input wire logic [1:0]      req_lock,
  input wire logic [1:0]      req_size,
  input wire logic [1:0]      rd_lock_type,
  input wire logic [1:0]      rd_beat_size,
  input wire logic [8:0]      req_user,
  input wire logic [8:0]      rd_addr_user_attr,
  input wire logic [ID_W-1:0] rd_request_id,
  input wire logic [ID_W-1:0] rd_data_id,
  input wire logic [ID_W-1:0] beat_id,
  input wire logic [ID_W-1:0] spec_read_id,
  input wire logic [ID_W-1:0] spec_id,
  input wire logic [63:0]     rd_data,
  input wire logic [63:0]     beat_data,
  input wire logic [7:0]      rd_data_check_bits,
  input wire logic [7:0]      beat_check,
  input wire logic [3:0]      spec_read_info,
  input wire logic [3:0]      spec_info
);
  default clocking cb @(posedge mclk); endclocking
  default disable iff (!reset_n);
  ////////////////////////////////////////////////////////////////////////////
  addr_load_a: assert property (
    req_valid && req_ready && out_clock_enable |=> rd_addr_valid
    && !req_ready && rd_addr_user_attr == $past(req_user)
    && rd_lock_type == $past(req_lock) && rd_beat_size == $past(req_size))
    else $error("address fields not loaded");
  out_gate_a: assert property (
    !out_clock_enable |=> $stable({rd_addr_valid, rd_ready, rd_request_id,
    rd_addr_user_attr})) else $error("output moved without enable");
  addr_done_a: assert property (
    rd_addr_valid && rd_addr_ready && in_clock_enable && out_clock_enable
    |=> !rd_addr_valid && req_ready) else $error("address not retired");
  in_gate_a: assert property (
    !in_clock_enable |=> !spec_valid) else $error("input taken without enable");
  spec_pulse_a: assert property (
    in_clock_enable && spec_read_info != 4'h0 |=> spec_valid
    && spec_info == $past(spec_read_info) && spec_id == $past(spec_read_id))
    else $error("spec report lost");
  spec_quiet_a: assert property (
    in_clock_enable && spec_read_info == 4'h0 |=> !spec_valid)
    else $error("spec report from zero info");
  beat_push_a: assert property (
    in_clock_enable && rd_valid && rd_ready && !beat_valid |=> beat_valid
    && beat_data == $past(rd_data) && beat_id == $past(rd_data_id)
    && beat_check == (BUS_ECC_EN ? $past(rd_data_check_bits) : 8'h00))
    else $error("beat not stored");
  beat_hold_a: assert property (
    beat_valid && !beat_ready |=> beat_valid && $stable(beat_data)
    && $stable(beat_id)) else $error("head beat moved");
endmodule
bind armp_read_port armp_read_port_chk #(
  .BUS_ECC_EN (BUS_ECC_EN),
  .ID_W       (ID_W)
) u_chk (.*);

// ===== tb/armp_far_model.sv
// Behavioural interconnect answering the read master port
`timescale 1ns/1ps
module armp_far_model (
  input  wire logic        mclk,
  input  wire logic        in_clock_enable,
  input  wire logic        slow,
  input  wire logic        rd_addr_valid,
  input  wire logic [4:0]  rd_request_id,
  output logic             rd_addr_ready,
  output logic [63:0]      rd_data,
  output logic [7:0]       rd_data_check_bits,
  output logic [4:0]       rd_data_id,
  output logic             rd_last,
  output logic [1:0]       rd_resp,
  output logic             rd_valid,
  input  wire logic        rd_ready,
  output logic [3:0]       spec_read_info,
  output logic [4:0]       spec_read_id
);
  logic [4:0] pend_q[$];
  logic       hs_a;
  logic       hs_d;
  logic [3:0] info;
  initial
  begin
    {rd_addr_ready, rd_valid, rd_last, rd_resp, rd_data} = '0;
    {rd_data_check_bits, rd_data_id, spec_read_info, spec_read_id} = '0;
  end
  always
  begin
    @(posedge mclk);
    hs_a = rd_addr_valid && rd_addr_ready && in_clock_enable;
    hs_d = rd_valid && rd_ready && in_clock_enable;
    @(negedge mclk);
    info = 4'h0;
    if (hs_a)
      pend_q.push_back(rd_request_id);
    // Slow mode stalls the address channel every other cycle
    rd_addr_ready = slow ? ~rd_addr_ready : 1'b1;
    if (hs_d || !rd_valid)
    begin
      if (pend_q.size() > 0)
      begin
        rd_data_id = pend_q.pop_front();
        rd_data = 64'hC3C3_0000_0000_0000 | 64'(rd_data_id);
        rd_data_check_bits = {3'h0, rd_data_id};
        {rd_valid, rd_last, rd_resp} = {2'h3, rd_data_id[1:0]};
        info = 4'h5;
      end
      else
      begin
        // Released lines do not keep the old beat
        rd_valid = 1'b0;
        rd_data = ~rd_data;
        rd_data_id = ~rd_data_id;
      end
    end
    spec_read_info = info;
    spec_read_id = (info != 4'h0) ? rd_data_id : ~spec_read_id;
  end
endmodule

// ===== tb/tb_top.sv
// Self-checking bench for the read master port
`timescale 1ns/1ps
module tb_top;
  logic        mclk, reset_n, in_clock_enable, out_clock_enable, slow;
  logic        req_valid, req_ready, rd_addr_valid, rd_addr_ready, rd_last;
  logic        rd_valid, rd_ready, beat_valid, beat_ready, beat_last;
  logic        spec_valid;
  logic [4:0]  req_id, rd_request_id, rd_data_id, spec_read_id, beat_id;
  logic [4:0]  spec_id;
  logic [1:0]  req_lock, req_size, rd_lock_type, rd_beat_size, rd_resp;
  logic [1:0]  beat_resp;
  logic [2:0]  req_prot, rd_prot;
  logic [8:0]  req_user, rd_addr_user_attr;
  logic [63:0] rd_data, beat_data;
  logic [7:0]  rd_data_check_bits, beat_check;
  logic [3:0]  spec_read_info, spec_info;
  int          error_cnt;
  int          n_compared;
  armp_read_port dut (.*);
  armp_far_model far (.*);
  ////////////////////////////////////////////////////////////////////////////
  task automatic chk(input logic [63:0] seen, exp);
    n_compared++;
    if (seen !== exp)
    begin
      error_cnt++;
      $display("wrong value at %0t: got %0h want %0h", $time, seen, exp);
    end
  endtask
  task automatic end_sim;
    if (error_cnt == 0 && n_compared > 0)
      $display("NO MISMATCHES");
    else
      $display("MISMATCHES SEEN");
    $finish;
  endtask
  task automatic req(input logic [4:0] id, input logic [1:0] lk, sz);
    // Wait first: a back-to-back call must not rewrite valid in one step
    for (int n = 0; n < 40 && req_ready !== 1'b1; n++)
      @(negedge mclk);
    {req_valid, req_id, req_lock, req_size} = {1'b1, id, lk, sz};
    req_user = {id, lk, sz};
    req_prot = {lk[0], sz};
    @(negedge mclk);
    req_valid = 1'b0;
    chk(rd_addr_valid, 1'b1);
    chk(rd_addr_user_attr, {id, lk, sz});
    chk(rd_prot, {lk[0], sz});
    chk(rd_lock_type, lk);
    chk(rd_beat_size, sz);
    chk(rd_request_id, id);
  endtask
  task automatic drain(input logic [4:0] id);
    // One edge apart so ready never rises where it just fell
    @(negedge mclk);
    for (int n = 0; n < 40 && beat_valid !== 1'b1; n++)
      @(negedge mclk);
    chk(beat_valid, 1'b1);
    chk(beat_id, id);
    chk(beat_data, 64'hC3C3_0000_0000_0000 | 64'(id));
    chk(beat_check, 8'h00);
    chk(beat_last, 1'b1);
    chk(beat_resp, 2'(id));
    beat_ready = 1'b1;
    @(negedge mclk);
    beat_ready = 1'b0;
  endtask
  ////////////////////////////////////////////////////////////////////////////
  task automatic t_codes;
    for (int i = 0; i < 4; i++)
    begin
      req(5'(i + 3), 2'(i % 3), 2'(i));
      drain(5'(i + 3));
      chk(spec_info, 4'h5);
      chk(spec_id, 5'(i + 3));
    end
  endtask
  task automatic t_fill;
    slow = 1'b1;
    for (int k = 0; k < 5; k++)
      req(5'(k + 16), 2'h0, 2'h3);
    repeat (8) @(negedge mclk);
    chk(rd_ready, 1'b0);
    slow = 1'b0;
    for (int k = 0; k < 5; k++)
      drain(5'(k + 16));
    chk(beat_valid, 1'b0);
  endtask
  task automatic t_enables;
    {in_clock_enable, out_clock_enable} = 2'h0;
    {req_valid, req_id, req_user} = {1'b1, 5'h1E, 9'h0AB};
    repeat (4) @(negedge mclk);
    chk(rd_addr_valid, 1'b0);
    out_clock_enable = 1'b1;
    repeat (4) @(negedge mclk);
    req_valid = 1'b0;
    chk(rd_addr_valid, 1'b1);
    chk(rd_addr_user_attr, 9'h0AB);
    in_clock_enable = 1'b1;
    drain(5'h1E);
  endtask
  ////////////////////////////////////////////////////////////////////////////
  initial
  begin
    mclk = 1'b0;
    forever #4 mclk = ~mclk;
  end
  initial
  begin
    {reset_n, in_clock_enable, out_clock_enable, slow} = 4'h6;
    {req_valid, beat_ready, req_id, req_lock, req_prot} = '0;
    {req_size, req_user, error_cnt, n_compared} = '0;
    repeat (16) @(negedge mclk);
    chk({req_ready, rd_addr_valid, rd_ready, beat_valid, spec_valid}, 5'h0);
    reset_n = 1'b1;
    @(negedge mclk);
    chk($bits(dut.rd_request_id), armp_pkg::NO_COH_ID_W);
    t_codes;
    t_fill;
    t_enables;
    end_sim;
  end
  // Whole run needs well under a thousand cycles
  initial
  begin
    #20000;
    error_cnt++;
    end_sim;
  end
endmodule
